// *** core/sqr_pkg.sv ***
// Constants shared by the soft bandwidth regulator block: register map, field layout,
// reset values and the fixed-point format of the rate accumulator.
// Assumes a 32-bit APB register port and 4-bit QoS values.
package sqr_pkg;

   // ==========================================================================
   // Register byte offsets.
   localparam logic [11:0] OFF_CTRL     = 12'h000;
   localparam logic [11:0] OFF_RD_REPL  = 12'h004;
   localparam logic [11:0] OFF_WR_REPL  = 12'h008;
   localparam logic [11:0] OFF_RD_CFG   = 12'h00C;
   localparam logic [11:0] OFF_WR_CFG   = 12'h010;
   localparam logic [11:0] OFF_COMB_CFG = 12'h014;
   localparam logic [11:0] OFF_STATUS   = 12'h018;

   // ==========================================================================
   // Control register bit positions.
   localparam int unsigned CTRL_FORCE   = 0;
   localparam int unsigned CTRL_RD_EN   = 1;
   localparam int unsigned CTRL_WR_EN   = 2;
   localparam int unsigned CTRL_COMB_EN = 3;
   localparam int unsigned CTRL_W       = 4;

   // ==========================================================================
   // Soft regulator configuration word layout.
   localparam int unsigned OVS_LSB  = 28;
   localparam int unsigned OVS_W    = 4;
   localparam int unsigned BUR_LSB  = 14;
   localparam int unsigned BUR_W    = 14;
   localparam int unsigned AVG_LSB  = 8;
   localparam int unsigned AVG_W    = 6;
   localparam int unsigned FLO_LSB  = 4;
   localparam int unsigned CEIL_LSB = 0;
   localparam int unsigned QOS_W    = 4;

   // ==========================================================================
   // Status register field positions.
   localparam int unsigned ST_RD_LSB   = 0;
   localparam int unsigned ST_WR_LSB   = 4;
   localparam int unsigned ST_COMB_LSB = 8;
   localparam int unsigned ST_OOS_LSB  = 12;

   // ==========================================================================
   // Reset values and accumulator format.
   localparam logic [31:0]      CTRL_RST = 32'h0000_0000;
   localparam logic [31:0]      CFG_RST  = 32'h0000_000F;
   localparam logic [QOS_W-1:0] REPL_RST = 4'h0;
   localparam logic [QOS_W-1:0] QOS_RST  = 4'h0;
   localparam int unsigned      FRAC_W   = 6;

endpackage : sqr_pkg

// *** core/sqr_soft_regulator.sv ***
// One soft bandwidth regulator: a fixed-point beat accumulator and the QoS it implies.
// Assumes beats of one cycle arrive on beats; the regulator never holds traffic back.
`timescale 1ns/1ps
module sqr_soft_regulator #(
   parameter int unsigned BEAT_W = 10,
   parameter int unsigned ACC_W  = 24
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              enable,
   input  wire logic [31:0]       cfg,
   input  wire logic [BEAT_W-1:0] beats,
   output logic      [3:0]        regulated_qos_out,
   output logic                   out_of_spec
);

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_d;
   logic [ACC_W:0]   sum;
   logic [ACC_W-1:0] limit;
   logic [ACC_W-1:0] excess;
   logic [ACC_W-1:0] overspend_step;
   logic [3:0]       qos_ceiling;
   logic [3:0]       qos_floor;
   logic [3:0]       lowered;

   assign qos_ceiling = cfg[sqr_pkg::CEIL_LSB +: sqr_pkg::QOS_W];
   assign qos_floor   = cfg[sqr_pkg::FLO_LSB +: sqr_pkg::QOS_W];
   assign limit = ACC_W'(cfg[sqr_pkg::BUR_LSB +: sqr_pkg::BUR_W]) << sqr_pkg::FRAC_W;

   // ==========================================================================
   // Accumulator: add incoming beats, drain the average rate, never below zero.
   always_comb begin
      sum = (ACC_W+1)'(beats) << sqr_pkg::FRAC_W;
      sum = sum + {1'b0, acc_q};
      if (sum < (ACC_W+1)'(cfg[sqr_pkg::AVG_LSB +: sqr_pkg::AVG_W])) begin
         acc_d = '0;
      end else begin
         sum = sum - (ACC_W+1)'(cfg[sqr_pkg::AVG_LSB +: sqr_pkg::AVG_W]);
         acc_d = sum[ACC_W] ? '1 : sum[ACC_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !enable) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_d;
      end
   end

   // ==========================================================================
   // QoS from the overspend: whole excess beats shifted down by the exponent.
   always_comb begin
      out_of_spec    = acc_q > limit;
      excess         = (acc_q - limit) >> sqr_pkg::FRAC_W;
      overspend_step = excess >> cfg[sqr_pkg::OVS_LSB +: sqr_pkg::OVS_W];
      if (overspend_step >= ACC_W'(qos_ceiling)) begin
         lowered = 4'h0;
      end else begin
         lowered = qos_ceiling - overspend_step[3:0];
      end
      if (!out_of_spec) begin
         regulated_qos_out = qos_ceiling;
      end else if (lowered < qos_floor) begin
         regulated_qos_out = qos_floor;
      end else begin
         regulated_qos_out = lowered;
      end
   end

endmodule : sqr_soft_regulator

// *** core/sqr_qos_select.sv ***
// Final QoS selector for one address channel.
// Assumes the regulator values are already the ceiling when their regulator is disabled.
`timescale 1ns/1ps
module sqr_qos_select (
   input  wire logic       indiv_en,
   input  wire logic       comb_en,
   input  wire logic [3:0] indiv_qos,
   input  wire logic [3:0] comb_qos,
   input  wire logic       force_on,
   input  wire logic [3:0] replacement,
   input  wire logic [3:0] axi_qos,
   output logic      [3:0] final_qos
);

   always_comb begin
      if (indiv_en && comb_en) begin
         final_qos = (comb_qos < indiv_qos) ? comb_qos : indiv_qos;
      end else if (comb_en) begin
         final_qos = comb_qos;
      end else if (indiv_en) begin
         final_qos = indiv_qos;
      end else if (force_on) begin
         final_qos = replacement;
      end else begin
         final_qos = axi_qos;
      end
   end

endmodule : sqr_qos_select

// *** core/sqr_ingress_qos.sv ***
// Ingress port QoS logic: three soft rate regulators, replacement QoS values,
// final QoS selection per address channel and an APB register slave.
// Assumes all inputs are synchronous to clk; transfer beats are reported by the port.
//
// Behaviour
// - Regulators never stall traffic; they only substitute a lowered QoS value.
// - QoS is lowered in proportion to the channel's excess bandwidth.
// - Within allocation the regulated QoS equals the programmed ceiling.
// - Out of spec when accumulated beats exceed rate times cycles plus burst.
// - Excess beats shifted right by the exponent are subtracted from the ceiling.
// - Regulated QoS never below floor, and recovers as the accumulator drains.
// - The AXI port has read, write and combined regulators.
// - The AHB port uses only the combined regulator.
// - Exponent in bits 31:28, burst allowance in bits 27:14.
// - Average rate in bits 13:8, floor in 7:4, ceiling in 3:0.
// - Read, write and combined regulators each have their own configuration word.
// - Separate replacement QoS values for read and write address channels.
// - Replacement applies when forced and no regulator is enabled.
// - With regulators on, the lower of combined and individual QoS wins.
// - Regulators off: forced gives replacement, otherwise incoming QoS passes.
// - Each cycle the accumulator adds beats and subtracts the average rate.
// - The combined regulator counts read and write beats together.
`timescale 1ns/1ps
module sqr_ingress_qos #(
   parameter bit          IS_AHB = 1'b0,
   parameter int unsigned BEAT_W = 9,
   parameter int unsigned ACC_W  = 24
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // APB register port.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic      [31:0]       prdata,
   output logic                   pslverr,
   // Priority force pin.
   input  wire logic              external_priority_force_in,
   // Read address channel.
   input  wire logic              rd_xfer_valid,
   input  wire logic [BEAT_W-1:0] rd_xfer_beats,
   input  wire logic [3:0]        ar_qos_in,
   output logic      [3:0]        ar_qos_out,
   // Write address channel.
   input  wire logic              wr_xfer_valid,
   input  wire logic [BEAT_W-1:0] wr_xfer_beats,
   input  wire logic [3:0]        aw_qos_in,
   output logic      [3:0]        aw_qos_out
);

   // ==========================================================================
   // Register storage.
   logic [sqr_pkg::CTRL_W-1:0] ctrl_q;
   logic [3:0]                 read_priority_replacement_q;
   logic [3:0]                 write_priority_replacement_q;
   logic [31:0]                read_soft_regulator_cfg_q;
   logic [31:0]                write_soft_regulator_cfg_q;
   logic [31:0]                combined_soft_regulator_cfg_q;

   // ==========================================================================
   // APB slave state.
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        access;
   logic        commit;
   logic        wr_commit;
   logic        addr_hit;
   logic [31:0] rd_word;

   // ==========================================================================
   // Regulator and selection signals.
   logic              software_priority_force_bit;
   logic              force_on;
   logic              rd_en;
   logic              wr_en;
   logic              comb_en;
   logic [BEAT_W-1:0] rd_beats;
   logic [BEAT_W-1:0] wr_beats;
   logic [BEAT_W:0]   comb_beats;
   logic [3:0]        rd_qos;
   logic [3:0]        wr_qos;
   logic [3:0]        comb_qos;
   logic              rd_oos;
   logic              wr_oos;
   logic              comb_oos;
   logic [3:0]        rd_indiv_qos;
   logic [3:0]        wr_indiv_qos;
   logic [3:0]        comb_sel_qos;
   logic [3:0]        ar_final;
   logic [3:0]        aw_final;
   logic [3:0]        ar_qos_out_q;
   logic [3:0]        aw_qos_out_q;

   assign pready     = pready_q;
   assign prdata     = prdata_q;
   assign pslverr    = pslverr_q;
   assign ar_qos_out = ar_qos_out_q;
   assign aw_qos_out = aw_qos_out_q;

   // ==========================================================================
   // APB decode. The access phase takes one wait state so that pready, prdata
   // and pslverr all come straight from flip-flops.
   assign access    = psel && penable;
   assign commit    = access && pready_q;
   assign wr_commit = commit && pwrite && addr_hit;

   always_comb begin
      addr_hit = 1'b1;
      rd_word  = 32'h0000_0000;
      case (paddr)
         sqr_pkg::OFF_CTRL: begin
            rd_word[sqr_pkg::CTRL_W-1:0] = ctrl_q;
         end
         sqr_pkg::OFF_RD_REPL: begin
            rd_word[3:0] = read_priority_replacement_q;
         end
         sqr_pkg::OFF_WR_REPL: begin
            rd_word[3:0] = write_priority_replacement_q;
         end
         sqr_pkg::OFF_RD_CFG: begin
            rd_word = read_soft_regulator_cfg_q;
         end
         sqr_pkg::OFF_WR_CFG: begin
            rd_word = write_soft_regulator_cfg_q;
         end
         sqr_pkg::OFF_COMB_CFG: begin
            rd_word = combined_soft_regulator_cfg_q;
         end
         sqr_pkg::OFF_STATUS: begin
            rd_word[sqr_pkg::ST_RD_LSB +: 4]   = rd_qos;
            rd_word[sqr_pkg::ST_WR_LSB +: 4]   = wr_qos;
            rd_word[sqr_pkg::ST_COMB_LSB +: 4] = comb_qos;
            rd_word[sqr_pkg::ST_OOS_LSB +: 3]  = {comb_oos, wr_oos, rd_oos};
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   // Handshake: pready rises after the first access cycle and drops after the commit.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (access && !pready_q) begin
         pready_q  <= 1'b1;
         prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr_q <= !addr_hit || (pwrite && paddr == sqr_pkg::OFF_STATUS);
      end else begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Control register: force bit and the three regulator enables.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= sqr_pkg::CTRL_RST[sqr_pkg::CTRL_W-1:0];
      end else if (wr_commit && paddr == sqr_pkg::OFF_CTRL) begin
         ctrl_q <= pwdata[sqr_pkg::CTRL_W-1:0];
      end
   end

   // Replacement QoS values, one per address channel.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         read_priority_replacement_q  <= sqr_pkg::REPL_RST;
         write_priority_replacement_q <= sqr_pkg::REPL_RST;
      end else if (wr_commit && paddr == sqr_pkg::OFF_RD_REPL) begin
         read_priority_replacement_q  <= pwdata[3:0];
      end else if (wr_commit && paddr == sqr_pkg::OFF_WR_REPL) begin
         write_priority_replacement_q <= pwdata[3:0];
      end
   end

   // Regulator configuration words, all with the same field layout.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         read_soft_regulator_cfg_q     <= sqr_pkg::CFG_RST;
         write_soft_regulator_cfg_q    <= sqr_pkg::CFG_RST;
         combined_soft_regulator_cfg_q <= sqr_pkg::CFG_RST;
      end else if (wr_commit && paddr == sqr_pkg::OFF_RD_CFG) begin
         read_soft_regulator_cfg_q     <= pwdata;
      end else if (wr_commit && paddr == sqr_pkg::OFF_WR_CFG) begin
         write_soft_regulator_cfg_q    <= pwdata;
      end else if (wr_commit && paddr == sqr_pkg::OFF_COMB_CFG) begin
         combined_soft_regulator_cfg_q <= pwdata;
      end
   end

   // ==========================================================================
   // Enables. An AHB port has one channel, so only the combined regulator runs.
   assign software_priority_force_bit = ctrl_q[sqr_pkg::CTRL_FORCE];
   assign force_on = external_priority_force_in || software_priority_force_bit;
   assign rd_en    = !IS_AHB && ctrl_q[sqr_pkg::CTRL_RD_EN];
   assign wr_en    = !IS_AHB && ctrl_q[sqr_pkg::CTRL_WR_EN];
   assign comb_en  = ctrl_q[sqr_pkg::CTRL_COMB_EN];

   // Beats reach the regulators only; there is no ready toward the master.
   assign rd_beats   = rd_xfer_valid ? rd_xfer_beats : '0;
   assign wr_beats   = wr_xfer_valid ? wr_xfer_beats : '0;
   assign comb_beats = {1'b0, rd_beats} + {1'b0, wr_beats};

   // ==========================================================================
   // The three regulators.
   sqr_soft_regulator #(
      .BEAT_W (BEAT_W),
      .ACC_W  (ACC_W)
   ) u_rd_reg (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .enable            (rd_en),
      .cfg               (read_soft_regulator_cfg_q),
      .beats             (rd_beats),
      .regulated_qos_out (rd_qos),
      .out_of_spec       (rd_oos)
   );

   sqr_soft_regulator #(
      .BEAT_W (BEAT_W),
      .ACC_W  (ACC_W)
   ) u_wr_reg (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .enable            (wr_en),
      .cfg               (write_soft_regulator_cfg_q),
      .beats             (wr_beats),
      .regulated_qos_out (wr_qos),
      .out_of_spec       (wr_oos)
   );

   sqr_soft_regulator #(
      .BEAT_W (BEAT_W + 1),
      .ACC_W  (ACC_W)
   ) u_comb_reg (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .enable            (comb_en),
      .cfg               (combined_soft_regulator_cfg_q),
      .beats             (comb_beats),
      .regulated_qos_out (comb_qos),
      .out_of_spec       (comb_oos)
   );

   // ==========================================================================
   // Final selection per address channel, registered toward the network.
   assign rd_indiv_qos = rd_qos;
   assign wr_indiv_qos = wr_qos;
   assign comb_sel_qos = comb_qos;

   sqr_qos_select u_ar_sel (
      .indiv_en    (rd_en),
      .comb_en     (comb_en),
      .indiv_qos   (rd_indiv_qos),
      .comb_qos    (comb_sel_qos),
      .force_on    (force_on),
      .replacement (read_priority_replacement_q),
      .axi_qos     (ar_qos_in),
      .final_qos   (ar_final)
   );

   sqr_qos_select u_aw_sel (
      .indiv_en    (wr_en),
      .comb_en     (comb_en),
      .indiv_qos   (wr_indiv_qos),
      .comb_qos    (comb_sel_qos),
      .force_on    (force_on),
      .replacement (write_priority_replacement_q),
      .axi_qos     (aw_qos_in),
      .final_qos   (aw_final)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ar_qos_out_q <= sqr_pkg::QOS_RST;
         aw_qos_out_q <= sqr_pkg::QOS_RST;
      end else begin
         ar_qos_out_q <= ar_final;
         aw_qos_out_q <= aw_final;
      end
   end

endmodule : sqr_ingress_qos

// *** tb/sqr_ingress_qos_assertions.sv ***
// Checker for the ingress QoS block; it watches only the top module's ports.
// Assumes the register map of sqr_pkg and that the APB master never overlaps requests.
`timescale 1ns/1ps
module sqr_ingress_qos_assertions (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        external_priority_force_in,
   input wire logic [3:0]  ar_qos_in,
   input wire logic [3:0]  ar_qos_out,
   input wire logic [3:0]  aw_qos_in,
   input wire logic [3:0]  aw_qos_out
);
   // ==========================================================================
   // Shadow of the control, replacement and combined configuration registers.
   logic [3:0]  ctrl_q;
   logic [3:0]  rrep_q;
   logic [3:0]  wrep_q;
   logic [31:0] ccfg_q;
   logic [3:0]  quiet_q;
   logic        wdone;
   logic        frc;
   logic        noen;
   assign wdone = psel && penable && pready && pwrite && !pslverr;
   assign frc   = external_priority_force_in || ctrl_q[0];
   assign noen  = ctrl_q[3:1] == 3'h0;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= 4'h0;
         rrep_q <= 4'h0;
         wrep_q <= 4'h0;
         ccfg_q <= 32'h0000_000F;
      end else if (wdone) begin
         if (paddr == sqr_pkg::OFF_CTRL) ctrl_q <= pwdata[3:0];
         if (paddr == sqr_pkg::OFF_RD_REPL) rrep_q <= pwdata[3:0];
         if (paddr == sqr_pkg::OFF_WR_REPL) wrep_q <= pwdata[3:0];
         if (paddr == sqr_pkg::OFF_COMB_CFG) ccfg_q <= pwdata;
      end
   end
   // Counts quiet cycles since the last write so settling regulators are not judged.
   always_ff @(posedge clk) begin
      if (sys_rst || (psel && pwrite)) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
   end
   // ==========================================================================
   // Properties.
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready not given after one wait state");
   a_ready_in_access: assert property (pready |-> $past(psel && penable))
      else $error("ready outside an access");
   a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero while idle");
   a_bad_addr_err: assert property (psel && penable && !pready && paddr > sqr_pkg::OFF_STATUS
      |=> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_axi_passes: assert property (noen && !frc |=> ar_qos_out == $past(ar_qos_in) &&
      aw_qos_out == $past(aw_qos_in))
      else $error("incoming QoS not passed through");
   a_rd_replaced: assert property (noen && frc |=> ar_qos_out == $past(rrep_q))
      else $error("read replacement QoS not applied");
   a_wr_replaced: assert property (noen && frc |=> aw_qos_out == $past(wrep_q))
      else $error("write replacement QoS not applied");
   a_comb_bounds: assert property (ctrl_q == 4'h8 && quiet_q > 4'h3 &&
      ccfg_q[7:4] <= ccfg_q[3:0] |-> aw_qos_out <= ccfg_q[3:0] && aw_qos_out >= ccfg_q[7:4])
      else $error("regulated QoS outside floor and ceiling");
   c_write_done: cover property (wdone);
   c_refused: cover property (pslverr);
   c_at_floor: cover property (ctrl_q == 4'h8 && aw_qos_out == ccfg_q[7:4]);
endmodule : sqr_ingress_qos_assertions

// *** tb/sqr_master_model.sv ***
// Behavioural transfer source standing in for the master at the ingress port.
// Assumes the testbench pulses start for one cycle and lets a run finish before the next.
`timescale 1ns/1ps
module sqr_master_model (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       start,
   input  wire logic [7:0] runs,
   input  wire logic [8:0] rd_len,
   input  wire logic [8:0] wr_len,
   output logic            rd_xfer_valid,
   output logic      [8:0] rd_xfer_beats,
   output logic            wr_xfer_valid,
   output logic      [8:0] wr_xfer_beats
);
   logic [7:0] left_q;
   logic [8:0] junk_q;
   // Transfers go out every cycle of a run; no ready exists, so nothing holds them back.
   always_ff @(posedge clk) begin
      if (sys_rst) left_q <= 8'h00;
      else if (start) left_q <= runs;
      else if (left_q != 8'h00) left_q <= left_q - 8'h01;
   end
   // Beat counts change every cycle outside a transfer so stale values are never counted.
   always_ff @(posedge clk) begin
      if (sys_rst) junk_q <= 9'h155;
      else junk_q <= junk_q + 9'h0A7;
   end
   assign rd_xfer_valid = (left_q != 8'h00) && (rd_len != 9'h000);
   assign wr_xfer_valid = (left_q != 8'h00) && (wr_len != 9'h000);
   assign rd_xfer_beats = rd_xfer_valid ? rd_len : junk_q;
   assign wr_xfer_beats = wr_xfer_valid ? wr_len : ~junk_q;
endmodule : sqr_master_model

// *** tb/sqr_ingress_qos_tb.sv ***
// Self-checking testbench for the ingress QoS block with an APB master and a traffic model.
// Assumes one wait state on APB and two cycles from a counted beat to the output QoS.
`timescale 1ns/1ps
module sqr_ingress_qos_tb;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        force_pin = 1'b0;
   logic [3:0]  ar_qos_in = 4'h0;
   logic [3:0]  aw_qos_in = 4'h0;
   logic [3:0]  ar_qos_out;
   logic [3:0]  aw_qos_out;
   logic        start = 1'b0;
   logic [7:0]  runs = 8'h00;
   logic [8:0]  rd_len = 9'h000;
   logic [8:0]  wr_len = 9'h000;
   logic        rd_v;
   logic        wr_v;
   logic [8:0]  rd_b;
   logic [8:0]  wr_b;
   int          err_count = 0;
   int          checks_done = 0;
   always #5 clk = ~clk;
   sqr_ingress_qos u_sqr_ingress_qos (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .external_priority_force_in(force_pin),
      .rd_xfer_valid(rd_v), .rd_xfer_beats(rd_b), .ar_qos_in(ar_qos_in),
      .ar_qos_out(ar_qos_out), .wr_xfer_valid(wr_v), .wr_xfer_beats(wr_b),
      .aw_qos_in(aw_qos_in), .aw_qos_out(aw_qos_out));
   sqr_master_model u_sqr_master_model (.clk(clk), .sys_rst(sys_rst), .start(start),
      .runs(runs), .rd_len(rd_len), .wr_len(wr_len), .rd_xfer_valid(rd_v),
      .rd_xfer_beats(rd_b), .wr_xfer_valid(wr_v), .wr_xfer_beats(wr_b));
   // ==========================================================================
   // Shared tasks.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      check({31'h0, e}, 32'h0);
   endtask : wr
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
   endtask : rd_chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic pulse(input logic [8:0] r, input logic [8:0] w, input logic [7:0] n);
      @(posedge clk);
      rd_len <= r;
      wr_len <= w;
      runs <= n;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask : pulse
   task automatic qos(input logic [3:0] ar, input logic [3:0] aw);
      check({28'h0, ar_qos_out}, {28'h0, ar});
      check({28'h0, aw_qos_out}, {28'h0, aw});
   endtask : qos
   // ==========================================================================
   // Scenarios.
   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      rd_chk(sqr_pkg::OFF_CTRL, 32'h0);
      rd_chk(sqr_pkg::OFF_RD_REPL, 32'h0);
      rd_chk(sqr_pkg::OFF_WR_CFG, 32'h0000_000F);
      for (int i = 0; i < 3; i++) begin
         wr(sqr_pkg::OFF_RD_CFG + 12'(4 * i), 32'hA5C3_96E1 + i);
         rd_chk(sqr_pkg::OFF_RD_CFG + 12'(4 * i), 32'hA5C3_96E1 + i);
      end
      apb(1'b0, 12'h01C, 32'h0, r, e);
      check({31'h0, e}, 32'h1);
      check(r, 32'h0);
      apb(1'b1, sqr_pkg::OFF_STATUS, 32'hFFFF_FFFF, r, e);
      check({31'h0, e}, 32'h1);
   endtask : t_regs
   task automatic t_select();
      @(posedge clk);
      ar_qos_in <= 4'h5;
      aw_qos_in <= 4'h9;
      tick(2);
      qos(4'h5, 4'h9);
      wr(sqr_pkg::OFF_RD_REPL, 32'h3);
      wr(sqr_pkg::OFF_WR_REPL, 32'hC);
      force_pin <= 1'b1;
      tick(2);
      qos(4'h3, 4'hC);
      force_pin <= 1'b0;
      wr(sqr_pkg::OFF_CTRL, 32'h1);
      tick(2);
      qos(4'h3, 4'hC);
      wr(sqr_pkg::OFF_COMB_CFG, 32'h1000_902C);
      wr(sqr_pkg::OFF_CTRL, 32'h9);
      tick(3);
      qos(4'hC, 4'hC);
   endtask : t_select
   task automatic t_regulate();
      logic [31:0] r;
      logic        e;
      wr(sqr_pkg::OFF_CTRL, 32'h8);
      tick(30);
      pulse(9'd4, 9'd4, 8'd1);
      tick(2);
      qos(4'hA, 4'hA);
      tick(40);
      qos(4'hC, 4'hC);
      pulse(9'd8, 9'd0, 8'd1);
      tick(2);
      qos(4'hA, 4'hA);
      pulse(9'd8, 9'd0, 8'd20);
      tick(23);
      qos(4'h2, 4'h2);
      apb(1'b0, sqr_pkg::OFF_STATUS, 32'h0, r, e);
      check({25'h0, r[14:8]}, 32'h42);
      wr(sqr_pkg::OFF_RD_CFG, 32'h0000_0077);
      wr(sqr_pkg::OFF_CTRL, 32'hA);
      tick(3);
      qos(4'h2, 4'h2);
      tick(700);
      qos(4'h7, 4'hC);
   endtask : t_regulate
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_select();
      t_regulate();
      complete_run();
   end
   initial begin
      #100_000;
      err_count++;
      complete_run();
   end
endmodule : sqr_ingress_qos_tb
bind sqr_ingress_qos sqr_ingress_qos_assertions u_sqr_ingress_qos_assertions (.clk(clk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .external_priority_force_in(external_priority_force_in), .ar_qos_in(ar_qos_in),
   .ar_qos_out(ar_qos_out), .aw_qos_in(aw_qos_in), .aw_qos_out(aw_qos_out));
